// File: core/udl_irq_list.sv
// Notes on behaviour
// - enabled pending bit raises its routed line
// - enable bits 9:0, 30, 31, reset zero
// - writing one forces pending bit set
// - force register reads back pending bits
// - line select: zero normal, one fast
// - toggle view bits 9:0, rest zero
// - list words located from start pointer
// - fixed word order of the list
// - offset 15:0, count 25:16, flags above
// - setup word holds only an offset
// - control directions use one word each
// - other directions double buffered, two words
// - pending set by hardware, write-one clears
// - active cleared by hardware when count reaches zero, on a short packet, on skip
// - disabled endpoint tokens get no answer
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module udl_irq_list #(
  parameter int NUM_DIR = 10
) (
  // clock, reset and freeze
  input  wire logic                    sys_clk,
  input  wire logic                    nrst,
  input  wire logic                    clk_en,
  // register bus
  input  wire logic [31:0]             reg_addr,
  input  wire logic [31:0]             reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [31:0]             reg_rdata,
  // interrupt lines
  output logic                         irq_normal,
  output logic                         fast_interrupt_line,
  // events and endpoint state
  input  wire logic                    frame_tick,
  input  wire logic                    dev_status_evt,
  input  wire logic [NUM_DIR-1:0]      ep_toggle,
  input  wire logic [NUM_DIR-1:0]      skip_req,
  // token lookup and transfer end
  input  wire logic                    tok_valid,
  input  wire logic [2:0]              tok_ep,
  input  wire logic                    tok_in,
  input  wire logic                    tok_setup,
  output logic                         tok_ack,
  output udl_pkg::udl_res_t            tok_res,
  output logic      [15:0]             tok_offset,
  output logic      [9:0]              tok_count,
  input  wire logic                    xfer_done,
  input  wire logic [9:0]              xfer_bytes,
  input  wire logic                    xfer_short,
  // engine status and list memory port
  output logic                         busy,
  output logic      [31:0]             mem_addr,
  output logic                         mem_rd,
  output logic                         mem_wr,
  output logic      [31:0]             mem_wdata,
  input  wire logic [31:0]             mem_rdata
);
  import udl_pkg::*;

  // all state of the block in one record
  typedef struct packed {
    // register contents
    logic [31:0]        en_r;       // interrupt enables
    logic [31:0]        route_r;    // line select, one means fast line
    logic [31:0]        pend_r;     // pending interrupt bits
    logic [31:0]        lstart_r;   // list start pointer
    logic [NUM_DIR-1:0] tog_r;      // sampled data toggles
    logic [NUM_DIR-1:0] skipq_r;    // skip requests still to serve
    logic [NUM_DIR-1:0] bufsel_r;   // current buffer per direction
    logic [31:0]        rdata_r;    // read answer
    logic               irqn_r;     // normal line
    logic               irqf_r;     // fast line

    // list engine
    udl_state_t         st_r;       // engine state
    udl_op_t            op_r;       // operation in flight
    logic [2:0]         ep_r;       // endpoint of the operation
    logic               dir_r;      // direction of the operation
    logic               setup_r;    // setup word wanted
    logic [9:0]         bytes_r;    // bytes moved by the finished transfer
    logic               short_r;    // transfer ended short
    logic               busy_r;     // engine cannot take a request

    // outputs to memory and token side
    logic [31:0]        maddr_r;    // memory address
    logic               mrd_r;      // memory read strobe
    logic               mwr_r;      // memory write strobe
    logic [31:0]        mwdata_r;   // memory write data
    logic               ack_r;      // token answer pulse
    udl_res_t           res_r;      // token answer kind
    logic [15:0]        aoff_r;     // answered buffer offset
    logic [9:0]         acnt_r;     // answered byte count
  } udl_st_t;

  udl_st_t q_r;   // registered state
  udl_st_t q_nxt; // next state

  // decoder shared by every operation
  udl_list_if lst ();
  udl_list_map u_map (
    .lst (lst)
  );

  assign lst.ep      = q_r.ep_r;
  assign lst.dir_in  = q_r.dir_r;
  assign lst.setup   = q_r.setup_r;
  // buffer picked by the direction under lookup
  assign lst.buf_sel = q_r.bufsel_r[lst.sidx];
  assign lst.word    = mem_rdata;

  // every output leaves straight from the state record
  assign reg_rdata           = q_r.rdata_r;
  assign irq_normal          = q_r.irqn_r;
  assign fast_interrupt_line = q_r.irqf_r;
  assign tok_ack             = q_r.ack_r;
  assign tok_res             = q_r.res_r;
  assign tok_offset          = q_r.aoff_r;
  assign tok_count           = q_r.acnt_r;
  assign busy                = q_r.busy_r;
  assign mem_addr            = q_r.maddr_r;
  assign mem_rd              = q_r.mrd_r;
  assign mem_wr              = q_r.mwr_r;
  assign mem_wdata           = q_r.mwdata_r;

  // register bus, interrupt bookkeeping and list engine
  always_comb begin
    logic [31:0]        hw_set;   // events raised this cycle
    logic [31:0]        sw_set;   // bits forced by software
    logic [31:0]        sw_clr;   // bits cleared by software
    logic [31:0]        pend_new; // pending after this cycle
    logic [9:0]         left;     // byte count after the transfer
    logic               retire;   // buffer handed back to software
    logic [NUM_DIR-1:0] skip_pick;
    logic [3:0]         skip_idx;
    // scratch values start defined
    hw_set    = 32'h0000_0000;
    sw_set    = 32'h0000_0000;
    sw_clr    = 32'h0000_0000;
    pend_new  = 32'h0000_0000;
    left      = 10'h000;
    retire    = 1'b0;
    skip_pick = '0;
    skip_idx  = 4'h0;
    q_nxt     = q_r;
    // pulses drop after one cycle
    q_nxt.ack_r = 1'b0;
    q_nxt.mrd_r = 1'b0;
    q_nxt.mwr_r = 1'b0;

    // frame and device events arrive as one-cycle pulses
    hw_set[UDL_FRAME_BIT] = frame_tick;
    hw_set[UDL_DEV_BIT]   = dev_status_evt;
    q_nxt.tog_r   = ep_toggle;
    // skips wait until the engine is free
    q_nxt.skipq_r = q_r.skipq_r | skip_req;

    // register writes
    if (reg_wr) begin
      case (reg_addr)
        UDL_ENABLE_ADDR: begin
          q_nxt.en_r = reg_wdata & UDL_IRQ_BITS;
        end

        UDL_LINE_SEL_ADDR: begin
          q_nxt.route_r = reg_wdata & UDL_IRQ_BITS;
        end

        UDL_FORCE_ADDR: begin
          sw_set = reg_wdata & UDL_IRQ_BITS;
        end

        // write one to clear
        UDL_PENDING_ADDR: begin
          sw_clr = reg_wdata & UDL_IRQ_BITS;
        end

        // word aligned, low two bits dropped
        UDL_LIST_START_ADDR: begin
          q_nxt.lstart_r = {reg_wdata[31:2], 2'b00};
        end

        default: begin
          // unmapped writes are dropped
        end
      endcase
    end

    // register reads answer in the next cycle only
    q_nxt.rdata_r = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        UDL_ENABLE_ADDR:     q_nxt.rdata_r = q_r.en_r;
        UDL_LINE_SEL_ADDR:   q_nxt.rdata_r = q_r.route_r;
        UDL_PENDING_ADDR:    q_nxt.rdata_r = q_r.pend_r;
        UDL_FORCE_ADDR:      q_nxt.rdata_r = q_r.pend_r;
        UDL_TOGGLE_ADDR:     q_nxt.rdata_r = 32'(q_r.tog_r);
        UDL_LIST_START_ADDR: q_nxt.rdata_r = q_r.lstart_r;
        default:             q_nxt.rdata_r = 32'h0000_0000;
      endcase
    end

    // list engine: one operation at a time, completions before tokens before skips
    case (q_r.st_r)
      UDL_IDLE: begin
        // lowest queued skip wins
        for (int i = NUM_DIR - 1; i >= 0; i--) begin
          if (q_r.skipq_r[i]) begin
            skip_idx = 4'(i);
          end
        end

        // completions first, then tokens
        if (xfer_done) begin
          q_nxt.op_r    = UDL_OP_DONE;
          q_nxt.bytes_r = xfer_bytes;
          q_nxt.short_r = xfer_short;
          q_nxt.setup_r = 1'b0;
          q_nxt.st_r    = UDL_FETCH;
          q_nxt.busy_r  = 1'b1;
        end else if (tok_valid) begin
          // kept for the completion that follows
          q_nxt.op_r    = UDL_OP_TOKEN;
          q_nxt.ep_r    = tok_ep;
          q_nxt.dir_r   = tok_in;
          q_nxt.setup_r = tok_setup;
          q_nxt.st_r    = UDL_FETCH;
          q_nxt.busy_r  = 1'b1;
        end else if (|q_r.skipq_r) begin
          // hazard: the served skip bit is cleared only here, so new requests keep queueing
          q_nxt.op_r    = UDL_OP_SKIP;
          q_nxt.ep_r    = 3'(skip_idx[3:1]);
          q_nxt.dir_r   = skip_idx[0];
          q_nxt.setup_r = 1'b0;
          skip_pick     = NUM_DIR'(1) << skip_idx;
          q_nxt.skipq_r = (q_r.skipq_r & ~skip_pick) | skip_req;
          q_nxt.st_r    = UDL_FETCH;
          q_nxt.busy_r  = 1'b1;
        end
      end

      UDL_FETCH: begin
        // word address is the list start plus four bytes per word
        q_nxt.maddr_r = q_r.lstart_r + {25'h0, lst.widx, 2'b00};
        q_nxt.mrd_r   = 1'b1;
        q_nxt.st_r    = UDL_CAPT;
      end

      UDL_CAPT: begin
        // strobe seen by memory this cycle; data arrives next cycle
        q_nxt.st_r = UDL_WRITE;
      end

      UDL_WRITE: begin
        q_nxt.st_r   = UDL_IDLE;
        q_nxt.busy_r = 1'b0;

        case (q_r.op_r)
          UDL_OP_TOKEN: begin
            q_nxt.ack_r  = 1'b1;
            q_nxt.aoff_r = lst.offset;
            q_nxt.acnt_r = lst.count;
            if (q_r.setup_r) begin
              // setup is always taken
              q_nxt.res_r = UDL_RES_READY;
              hw_set[0]   = 1'b1;
            end else if (lst.disabled) begin
              // no data and no handshake
              q_nxt.res_r = UDL_RES_IGNORE;
            end else if (lst.active) begin
              q_nxt.res_r = UDL_RES_READY;
            end else if (lst.stall) begin
              // active outranks stall
              q_nxt.res_r = UDL_RES_STALL;
            end else begin
              q_nxt.res_r = UDL_RES_NAK;
            end
          end

          UDL_OP_DONE, UDL_OP_SKIP: begin
            // count runs down, a short packet or a skip hands the buffer back
            left = (q_r.bytes_r >= lst.count) ? 10'h000 : lst.count - q_r.bytes_r;
            // a skip moves no data
            if (q_r.op_r == UDL_OP_SKIP) begin
              left = lst.count;
            end

            retire = lst.active & ((left == 10'h000) | q_r.short_r | (q_r.op_r == UDL_OP_SKIP));
            q_nxt.maddr_r  = q_r.maddr_r;
            q_nxt.mwr_r    = 1'b1;
            q_nxt.mwdata_r = mem_rdata;
            q_nxt.mwdata_r[UDL_COUNT_LSB +: UDL_COUNT_W] = left;
            q_nxt.mwdata_r[UDL_ACTIVE_BIT] = lst.active & ~retire;
            // interrupt and buffer flip only on hand-back
            if (retire) begin
              hw_set[lst.sidx] = 1'b1;
              if (!lst.ctrl) begin
                q_nxt.bufsel_r[lst.sidx] = ~q_r.bufsel_r[lst.sidx];
              end
            end
          end

          default: begin
            q_nxt.mwr_r = 1'b0;
          end
        endcase
      end

      // unused encodings fall back to idle
      default: begin
        q_nxt.st_r   = UDL_IDLE;
        q_nxt.busy_r = 1'b0;
      end
    endcase

    // a set in the same cycle as a clear is kept
    pend_new     = (q_r.pend_r & ~sw_clr) | hw_set | sw_set;
    q_nxt.pend_r = pend_new & UDL_IRQ_BITS;

    // lines follow the pending bits, one cycle behind
    q_nxt.irqn_r = |(q_r.pend_r & q_r.en_r & ~q_r.route_r);
    q_nxt.irqf_r = |(q_r.pend_r & q_r.en_r & q_r.route_r);
  end

  // state register; clock enable low freezes everything
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      q_r          <= '0;
      // fields restated so reset values stay visible
      q_r.en_r     <= UDL_RESET_WORD;
      q_r.route_r  <= UDL_RESET_WORD;
      q_r.pend_r   <= UDL_RESET_WORD;
      q_r.bufsel_r <= UDL_RESET_DIRS;
      q_r.st_r     <= UDL_IDLE;
      q_r.op_r     <= UDL_OP_TOKEN;
      q_r.res_r    <= UDL_RES_NAK;
    end else if (clk_en) begin
      q_r <= q_nxt;
    end
  end
endmodule
`default_nettype wire

// File: include/udl_pkg.sv
// constants, field layouts and types shared by the interrupt and endpoint list logic
package udl_pkg;
  // register byte addresses
  localparam logic [31:0] UDL_LIST_START_ADDR = 32'h4008_0008; // endpoint list start pointer
  localparam logic [31:0] UDL_PENDING_ADDR    = 32'h4008_0020; // usb_interrupt_pending
  localparam logic [31:0] UDL_ENABLE_ADDR     = 32'h4008_0024; // usb_interrupt_enable
  localparam logic [31:0] UDL_FORCE_ADDR      = 32'h4008_0028; // usb_interrupt_force
  localparam logic [31:0] UDL_LINE_SEL_ADDR   = 32'h4008_002c; // usb_interrupt_line_select
  localparam logic [31:0] UDL_TOGGLE_ADDR     = 32'h4008_0034; // endpoint_data_toggle_view
  // implemented interrupt bits: endpoints 9:0, frame 30, device status 31
  localparam logic [31:0] UDL_IRQ_BITS        = 32'hc000_03ff;
  localparam int          UDL_FRAME_BIT       = 30;
  localparam int          UDL_DEV_BIT         = 31;
  localparam int          UDL_NUM_DIR         = 10;           // endpoint directions
  localparam logic [31:0] UDL_RESET_WORD      = 32'h0000_0000;
  localparam logic [9:0]  UDL_RESET_DIRS      = 10'h000;
  // list word fields
  localparam int          UDL_ACTIVE_BIT      = 31;
  localparam int          UDL_DISABLE_BIT     = 30;
  localparam int          UDL_STALL_BIT       = 29;
  localparam int          UDL_COUNT_LSB       = 16;
  localparam int          UDL_COUNT_W         = 10;
  localparam int          UDL_OFFSET_W        = 16;
  localparam logic [4:0]  UDL_SETUP_WIDX      = 5'h01;        // setup word position
  localparam logic [4:0]  UDL_CTRL_IN_WIDX    = 5'h02;        // control IN word position
  localparam logic [4:0]  UDL_EP1_WIDX        = 5'h04;        // first non-control word
  // engine states and token answers
  typedef enum logic [1:0] {UDL_IDLE, UDL_FETCH, UDL_CAPT, UDL_WRITE} udl_state_t;
  typedef enum logic [1:0] {UDL_OP_TOKEN, UDL_OP_DONE, UDL_OP_SKIP} udl_op_t;
  typedef enum logic [1:0] {UDL_RES_NAK, UDL_RES_READY, UDL_RES_STALL, UDL_RES_IGNORE} udl_res_t;
endpackage

// File: include/udl_list_if.sv
// signals between the list engine and the list word decoder
`timescale 1ns/1ps
`default_nettype none
interface udl_list_if;
  logic [2:0]  ep;        // endpoint number 0..4
  logic        dir_in;    // 1 for the IN direction
  logic        buf_sel;   // buffer 0 or 1
  logic        setup;     // select the setup word
  logic [31:0] word;      // list word fetched from memory
  logic [4:0]  widx;      // word index inside the list
  logic [3:0]  sidx;      // interrupt bit of the endpoint direction
  logic        ctrl;      // control endpoint, single buffer
  logic        active;    // buffer owned by hardware
  logic        disabled;  // endpoint switched off
  logic        stall;     // stall requested
  logic [9:0]  count;     // byte count field
  logic [15:0] offset;    // buffer address offset field
  modport engine  (output ep, dir_in, buf_sel, setup, word,
                   input  widx, sidx, ctrl, active, disabled, stall, count, offset);
  modport decoder (input  ep, dir_in, buf_sel, setup, word,
                   output widx, sidx, ctrl, active, disabled, stall, count, offset);
endinterface
`default_nettype wire

// File: core/udl_list_map.sv
// endpoint list word placement and field decode
`timescale 1ns/1ps
`default_nettype none
module udl_list_map (
  udl_list_if.decoder lst
);
  import udl_pkg::*;

  // word position: fixed list order, control words first, then two buffers per direction
  always_comb begin
    if (lst.setup) begin
      lst.widx = UDL_SETUP_WIDX;
    end else if (lst.ep == 3'h0) begin
      lst.widx = lst.dir_in ? UDL_CTRL_IN_WIDX : 5'h00;
    end else begin
      lst.widx = 5'({lst.ep[1:0] - 2'h1, lst.dir_in, lst.buf_sel}) + UDL_EP1_WIDX;
    end
  end

  // field decode; control words keep the disable position reserved
  always_comb begin
    lst.ctrl     = (lst.ep == 3'h0);
    lst.sidx     = {lst.ep, lst.dir_in};
    lst.offset   = lst.word[UDL_OFFSET_W-1:0];
    lst.count    = lst.setup ? 10'h000 : lst.word[UDL_COUNT_LSB +: UDL_COUNT_W];
    lst.active   = ~lst.setup & lst.word[UDL_ACTIVE_BIT];
    lst.stall    = ~lst.setup & lst.word[UDL_STALL_BIT];
    lst.disabled = ~lst.setup & ~lst.ctrl & lst.word[UDL_DISABLE_BIT];
  end
endmodule
`default_nettype wire

// File: bench/udl_irq_list_props.sv
// concurrent checks on the top ports of the interrupt and endpoint list block
`timescale 1ns/1ps
`default_nettype none
module udl_irq_list_props
  import udl_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        nrst,
  input wire logic        clk_en,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        irq_normal,
  input wire logic        fast_interrupt_line,
  input wire logic        tok_valid,
  input wire logic        tok_ack,
  input wire logic        xfer_done,
  input wire logic        busy,
  input wire logic [31:0] mem_addr,
  input wire logic        mem_rd,
  input wire logic        mem_wr
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // one register access taken on this edge
  sequence rd_at_s(logic [31:0] a); reg_rd && clk_en && reg_addr == a; endsequence
  sequence force_wr_s; reg_wr && clk_en && reg_addr == UDL_FORCE_ADDR; endsequence
  // engine fetch then answer: busy, fetch, two cycles later the result
  sequence fetch_s; busy ##1 (busy && mem_rd); endsequence
  // ones written to the force register must read back set, the read may follow after a gap cycle
  property force_back_p;
    logic [31:0] wd;
    (force_wr_s, wd = reg_wdata & UDL_IRQ_BITS) ##2 rd_at_s(UDL_FORCE_ADDR) |=> (reg_rdata & wd) == wd;
  endproperty
  enable_resv_a: assert property (rd_at_s(UDL_ENABLE_ADDR) |=> (reg_rdata & ~UDL_IRQ_BITS) == 32'h0)
    else $error("enable register shows reserved bits");
  line_resv_a: assert property (rd_at_s(UDL_LINE_SEL_ADDR) |=> (reg_rdata & ~UDL_IRQ_BITS) == 32'h0)
    else $error("line select shows reserved bits");
  toggle_resv_a: assert property (rd_at_s(UDL_TOGGLE_ADDR) |=> reg_rdata[31:10] == 22'h0)
    else $error("toggle view upper bits not zero");
  force_back_a: assert property (force_back_p)
    else $error("forced pending bit not set");
  enable_off_a: assert property (reg_wr && clk_en && reg_addr == UDL_ENABLE_ADDR && reg_wdata == 32'h0
      |-> ##2 (!irq_normal && !fast_interrupt_line))
    else $error("interrupt line high with all enables off");
  tok_walk_a: assert property (tok_valid && clk_en && !busy && !xfer_done |=> fetch_s ##2 (tok_ack && !busy))
    else $error("token answer not in four cycles");
  done_walk_a: assert property (xfer_done && clk_en && !busy |=> fetch_s ##2 (mem_wr && !busy))
    else $error("completion write-back missing");
  same_word_a: assert property (mem_wr |-> mem_addr == $past(mem_addr, 2))
    else $error("write-back address differs from fetch");
endmodule
bind udl_irq_list udl_irq_list_props u_props (.sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .irq_normal(irq_normal), .fast_interrupt_line(fast_interrupt_line), .tok_valid(tok_valid),
  .tok_ack(tok_ack), .xfer_done(xfer_done), .busy(busy), .mem_addr(mem_addr), .mem_rd(mem_rd),
  .mem_wr(mem_wr));
`default_nettype wire

// File: bench/udl_mem_model.sv
// memory holding the endpoint command/status list, seen across the system bus
`timescale 1ns/1ps
`default_nettype none
module udl_mem_model #(
  parameter logic [31:0] BASE = 32'h2000_0100
) (
  input  wire logic        sys_clk,
  input  wire logic [31:0] mem_addr,
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  input  wire logic [31:0] mem_wdata,
  output var  logic [31:0] mem_rdata
);
  logic      [31:0] words [32];                        // list words, loaded by the bench
  logic      [31:0] last_addr = 32'h0;                 // address of the latest fetch
  wire logic [4:0]  widx = 5'((mem_addr - BASE) >> 2); // word position inside the list
  initial mem_rdata = 32'h0;
  // answer one cycle after a fetch; otherwise a changing pattern, so stale data never passes as valid
  always @(posedge sys_clk) begin
    if (mem_rd) begin
      mem_rdata <= words[widx];
      last_addr <= mem_addr;
    end else begin
      mem_rdata <= ~mem_rdata;
    end
    // write-backs from the engine land in place, flags included
    if (mem_wr) begin
      words[widx] <= mem_wdata;
    end
  end
endmodule
`default_nettype wire

// File: bench/usb_dev_irq_and_ep_list_bench.sv
// self-checking bench: registers, interrupt lines and endpoint list engine
`timescale 1ns/1ps
`default_nettype none
module usb_dev_irq_and_ep_list_bench;
  import udl_pkg::*;
  localparam logic [31:0] BASE = 32'h2000_0100; // list placement in memory
  logic        sys_clk = 1'b0, nrst = 1'b0, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rd_pend = 1'b0;
  logic        frame_tick = 1'b0, dev_status_evt = 1'b0, tok_valid = 1'b0, tok_in = 1'b0, tok_setup = 1'b0;
  logic        xfer_done = 1'b0, xfer_short = 1'b0, irq_normal, fast_interrupt_line, tok_ack, busy, mem_rd, mem_wr;
  logic [31:0] reg_addr = '0, reg_wdata = '0, reg_rdata, mem_addr, mem_wdata, mem_rdata, v;
  logic [9:0]  ep_toggle = '0, skip_req = '0, xfer_bytes = '0, tok_count;
  logic [2:0]  tok_ep = '0;
  logic [15:0] tok_offset;
  udl_res_t    tok_res;
  logic [31:0] rq[$], tq[$], aq[$]; // expected reads, token answers, fetch addresses
  int          err_count = 0, cmp_count = 0, seed = 79;
  always #4 sys_clk = ~sys_clk;
  udl_irq_list #(.NUM_DIR(10)) DUT (.sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_normal(irq_normal),
    .fast_interrupt_line(fast_interrupt_line), .frame_tick(frame_tick), .dev_status_evt(dev_status_evt),
    .ep_toggle(ep_toggle), .skip_req(skip_req), .tok_valid(tok_valid), .tok_ep(tok_ep), .tok_in(tok_in),
    .tok_setup(tok_setup), .tok_ack(tok_ack), .tok_res(tok_res), .tok_offset(tok_offset), .tok_count(tok_count),
    .xfer_done(xfer_done), .xfer_bytes(xfer_bytes), .xfer_short(xfer_short), .busy(busy), .mem_addr(mem_addr),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
  udl_mem_model #(.BASE(BASE)) mem (.sys_clk(sys_clk), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // bus cycles: strobe for one cycle, then one idle cycle so no strobe is driven twice in a step
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    rq.push_back(exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
  endtask
  // token request; the answer is judged by the watcher below
  task automatic tok(input logic [2:0] ep, input logic din, input logic st, input udl_res_t res,
                     input logic [9:0] cnt, input logic [15:0] off, input int widx);
    int n;
    tq.push_back({4'h0, res, cnt, off});
    aq.push_back(BASE + 32'(4 * widx));
    tok_ep <= ep;
    tok_in <= din;
    tok_setup <= st;
    tok_valid <= 1'b1;
    @(posedge sys_clk);
    tok_valid <= 1'b0;
    for (n = 0; n < 20 && tok_ack !== 1'b1; n++) @(negedge sys_clk);
    if (n == 20) begin
      err_count++;
      test_done();
    end
    @(posedge sys_clk);
  endtask
  // completion of the last token's transfer; write-back and pending land within six cycles
  task automatic done(input logic [9:0] nb, input logic sh);
    xfer_bytes <= nb;
    xfer_short <= sh;
    xfer_done <= 1'b1;
    @(posedge sys_clk);
    xfer_done <= 1'b0;
    xfer_short <= 1'b0;
    repeat (6) @(posedge sys_clk);
  endtask
  task automatic lines(input logic [31:0] exp);
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("irq lines", {30'h0, irq_normal, fast_interrupt_line}, exp);
    @(posedge sys_clk);
  endtask
  // watcher: read data stands only in the cycle after the strobe, token answers only with the ack
  always @(posedge sys_clk) rd_pend <= reg_rd;
  always @(negedge sys_clk) begin
    if (rd_pend) chk("reg_rdata", reg_rdata, rq.pop_front());
    if (tok_ack === 1'b1) begin
      chk("token answer", {4'h0, tok_res, tok_count, tok_offset}, tq.pop_front());
      chk("fetch address", mem.last_addr, aq.pop_front());
    end
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    rd(UDL_ENABLE_ADDR, 32'h0);
    rd(UDL_LINE_SEL_ADDR, 32'h0);
    rd(UDL_TOGGLE_ADDR, 32'h0);
    rd(UDL_FORCE_ADDR, 32'h0);
    // list: control OUT and setup words carry reserved flags that must not turn into disable
    mem.words[0] = 32'h6008_0040;
    mem.words[1] = 32'he3ff_0080;
    mem.words[2] = 32'h0000_00c0;
    mem.words[4] = 32'h8010_0100;
    mem.words[5] = 32'h8020_0200;
    mem.words[6] = 32'h4004_0300;
    mem.words[18] = 32'ha001_0400;
    wr(UDL_LIST_START_ADDR, BASE);
    tok(3'd0, 1'b0, 1'b0, UDL_RES_STALL, 10'h008, 16'h0040, 0);
    tok(3'd0, 1'b0, 1'b1, UDL_RES_READY, 10'h000, 16'h0080, 1);
    tok(3'd0, 1'b1, 1'b0, UDL_RES_NAK, 10'h000, 16'h00c0, 2);
    tok(3'd1, 1'b0, 1'b0, UDL_RES_READY, 10'h010, 16'h0100, 4);
    done(10'h010, 1'b0);
    chk("list word 4", mem.words[4], 32'h0000_0100);
    tok(3'd1, 1'b0, 1'b0, UDL_RES_READY, 10'h020, 16'h0200, 5);
    done(10'h008, 1'b0);
    chk("list word 5", mem.words[5], 32'h8018_0200);
    tok(3'd1, 1'b0, 1'b0, UDL_RES_READY, 10'h018, 16'h0200, 5);
    done(10'h004, 1'b1);
    chk("short hand-back", mem.words[5], 32'h0014_0200);
    tok(3'd1, 1'b1, 1'b0, UDL_RES_IGNORE, 10'h004, 16'h0300, 6);
    tok(3'd4, 1'b1, 1'b0, UDL_RES_READY, 10'h001, 16'h0400, 18);
    skip_req <= 10'h200;
    @(posedge sys_clk);
    skip_req <= 10'h000;
    repeat (6) @(posedge sys_clk);
    chk("list word 18", mem.words[18], 32'h2001_0400);
    rd(UDL_PENDING_ADDR, 32'h0000_0205);
    // interrupt lines: enable, route, clear
    lines(32'h0);
    wr(UDL_ENABLE_ADDR, 32'hffff_ffff);
    rd(UDL_ENABLE_ADDR, 32'hc000_03ff);
    lines(32'h2);
    wr(UDL_LINE_SEL_ADDR, 32'hffff_ffff);
    rd(UDL_LINE_SEL_ADDR, 32'hc000_03ff);
    wr(UDL_LINE_SEL_ADDR, 32'h0000_0200);
    lines(32'h3);
    wr(UDL_PENDING_ADDR, 32'h0000_0005);
    lines(32'h1);
    wr(UDL_PENDING_ADDR, 32'h0000_0200);
    lines(32'h0);
    frame_tick <= 1'b1;
    dev_status_evt <= 1'b1;
    @(posedge sys_clk);
    frame_tick <= 1'b0;
    dev_status_evt <= 1'b0;
    @(posedge sys_clk);
    rd(UDL_PENDING_ADDR, 32'hc000_0000);
    lines(32'h2);
    v = $random(seed);
    wr(UDL_FORCE_ADDR, v);
    rd(UDL_FORCE_ADDR, 32'hc000_0000 | (v & UDL_IRQ_BITS));
    wr(UDL_FORCE_ADDR, 32'h0);
    rd(UDL_PENDING_ADDR, 32'hc000_0000 | (v & UDL_IRQ_BITS));
    v = $random(seed);
    ep_toggle <= v[9:0];
    repeat (3) @(posedge sys_clk);
    rd(UDL_TOGGLE_ADDR, {22'h0, v[9:0]});
    wr(32'h4008_0030, 32'hffff_ffff);
    rd(32'h4008_0030, 32'h0);
    wr(UDL_ENABLE_ADDR, 32'h0);
    lines(32'h0);
    clk_en <= 1'b0;
    wr(UDL_ENABLE_ADDR, 32'hffff_ffff);
    clk_en <= 1'b1;
    rd(UDL_ENABLE_ADDR, 32'h0);
    repeat (4) @(posedge sys_clk);
    test_done();
  end
endmodule
`default_nettype wire
